// ===== verilog/msr_pkg.sv
// Package: register map, field positions, reset values and timing for mode select block
package msr_pkg;
  // Register offsets (printed 0h and Eh are indices; byte address is four times)
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_SYNC = 4'hE;
  localparam logic [3:0] IDX_PINS = 4'h1;
  localparam logic [11:0] ADDR_CTRL = {6'h00, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_SYNC = {6'h00, IDX_SYNC, 2'h0};
  localparam logic [11:0] ADDR_PINS = {6'h00, IDX_PINS, 2'h0};
  // Field positions
  localparam int CTRL_DUAL_EDGE_BIT = 7;
  localparam int SYNC_REF_OUT_EN_BIT = 1;
  localparam int SYNC_SLAVE_BIT = 0;
  localparam int SYNC_DELAY_LSB = 8;
  localparam int SYNC_DELAY_W = 4;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SYNC_RESET = 32'h0000_0000;
  // Power-on calibration wait, in microseconds, short and long
  localparam int CAL_WAIT_SHORT_US = 10;
  localparam int CAL_WAIT_LONG_US = 100;
  localparam int CLK_MHZ = 100;
  localparam int CAL_WAIT_SHORT_CYC = CAL_WAIT_SHORT_US * CLK_MHZ;
  localparam int CAL_WAIT_LONG_CYC = CAL_WAIT_LONG_US * CLK_MHZ;
  // Quarter-rate reference counter width
  localparam int DIV_W = 2;
  typedef enum logic [1:0] {MSR_CAL_WAIT, MSR_CAL_GO, MSR_CAL_DONE} msr_cal_t;
endpackage

// ===== verilog/msr_sync_if.sv
// Interface: carries sync controls between the top and the divider module
`timescale 1ns/10ps
`default_nettype none
interface msr_sync_if;
  logic enable;
  logic slave;
  logic [msr_pkg::SYNC_DELAY_W-1:0] delay;
  logic ref_in;
  logic ref_out;
  logic aligned;
  modport ctl (output enable, output slave, output delay, output ref_in,
    input ref_out, input aligned);
  modport div (input enable, input slave, input delay, input ref_in,
    output ref_out, output aligned);
endinterface
`default_nettype wire

// ===== verilog/msr_ref_divider.sv
// Quarter-rate reference generator with slave alignment to the reference input
`timescale 1ns/10ps
`default_nettype none
module msr_ref_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  msr_sync_if.div sif
);
  localparam int DLY_LEN = 1 << msr_pkg::SYNC_DELAY_W;

  logic [msr_pkg::DIV_W-1:0] phase;
  logic [DLY_LEN-1:0] dly_line;
  logic ref_dly_q;
  logic ref_dly;
  logic ref_out_q;
  logic aligned_q;

  // --------------------------------------------------------------
  // Reference input delay line
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_line <= '0;
      ref_dly_q <= 1'b0;
    end else if (ce) begin
      dly_line <= {dly_line[DLY_LEN-2:0], sif.ref_in};
      ref_dly_q <= ref_dly;
    end
  end
  assign ref_dly = dly_line[sif.delay];

  // --------------------------------------------------------------
  // Divider counter and output
  // --------------------------------------------------------------
  // two-bit counter, realigned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
    end else if (ce) begin
      if (sif.slave && ref_dly && !ref_dly_q) begin
        phase <= 2'h1;
      end else begin
        phase <= phase + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_out_q <= 1'b0;
    end else if (ce) begin
      ref_out_q <= sif.enable & phase[1];
    end
  end

  // Sticky alignment seen flag, cleared when slave mode drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aligned_q <= 1'b0;
    end else if (ce) begin
      if (!sif.slave) begin
        aligned_q <= 1'b0;
      end else if (ref_dly && !ref_dly_q) begin
        aligned_q <= 1'b1;
      end
    end
  end

  assign sif.ref_out = ref_out_q;
  assign sif.aligned = aligned_q;
endmodule
`default_nettype wire

// ===== verilog/msr_mode_select.sv
// Top: control pin mode decode, APB registers and sync reference clock path
//
// Notes on behaviour
// - enabled reference outputs run at quarter clock
// - enable bit 1 at Eh, off after reset
// - slave mode aligns divided clocks to reference
// - reference delay set only in extended mode
// - pin high: interleaved sampling of in-phase input
// - pin low: channels convert own inputs
// - extended mode uses bit 7 at 0h
// - wait pin high lengthens, low shortens calibration wait
// - wait select from pin only, both modes
// - bandgap pin high selects 1.2V output level
// - extended mode while enable pin low; else defaults
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module msr_mode_select #(
  parameter int CAL_SHORT = msr_pkg::CAL_WAIT_SHORT_CYC,
  parameter int CAL_LONG = msr_pkg::CAL_WAIT_LONG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins
  input wire logic extended_control_enable_n,
  input wire logic dual_edge_select,
  input wire logic power_on_cal_wait_select,
  input wire logic bandgap_out_lvds_cm_select,
  input wire logic common_mode_out_coupling_select,
  input wire logic sync_reference_in,
  // Decoded modes
  output logic extended_control_mode,
  output logic dual_edge_mode,
  output logic quadrature_input_used,
  output logic lvds_cm_high,
  output logic inputs_dc_coupled,
  output logic cal_start,
  output logic sync_aligned,
  output logic sync_reference_out_first,
  output logic sync_reference_out_second
);
  msr_sync_if sif ();

  logic [31:0] ctrl_reg;
  logic [31:0] sync_reg;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] next_rdata;
  logic ecm_q;
  logic dual_q;
  logic lvds_q;
  logic dc_q;
  logic cal_start_q;
  logic wait_long;
  logic [31:0] cal_cnt;
  msr_pkg::msr_cal_t cal_state;

  // Address decode shared by read and write paths
  function automatic logic msr_mapped(input logic [11:0] a);
    msr_mapped = (a == msr_pkg::ADDR_CTRL) || (a == msr_pkg::ADDR_SYNC) ||
      (a == msr_pkg::ADDR_PINS);
  endfunction

  // --------------------------------------------------------------
  // APB access
  // --------------------------------------------------------------
  // Zero wait states; unmapped addresses answer with an error
  assign addr_ok = msr_mapped(paddr);
  assign wr_en = psel & penable & pwrite & ce & addr_ok & extended_control_mode;
  assign rd_en = psel & penable & ~pwrite & ce;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecm_q <= 1'b0;
    end else if (ce) begin
      ecm_q <= ~extended_control_enable_n;
    end
  end
  assign extended_control_mode = ecm_q;

  // Control register; returns to defaults while extended mode is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= msr_pkg::CTRL_RESET;
    end else if (ce) begin
      if (!extended_control_mode) begin
        ctrl_reg <= msr_pkg::CTRL_RESET;
      end else if (wr_en && paddr == msr_pkg::ADDR_CTRL) begin
        ctrl_reg <= pwdata;
      end
    end
  end

  // Sync register: output enable, slave select and reference delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= msr_pkg::SYNC_RESET;
    end else if (ce) begin
      if (!extended_control_mode) begin
        sync_reg <= msr_pkg::SYNC_RESET;
      end else if (wr_en && paddr == msr_pkg::ADDR_SYNC) begin
        sync_reg <= pwdata;
      end
    end
  end

  // Read mux; the pin view reports the block's own decoded state
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      msr_pkg::ADDR_CTRL: next_rdata = ctrl_reg;
      msr_pkg::ADDR_SYNC: next_rdata = sync_reg;
      msr_pkg::ADDR_PINS: next_rdata = {26'h0000000, sync_aligned, cal_start_q,
        dc_q, lvds_q, dual_q, ecm_q};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered in the setup phase so it stands during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end else if (ce && rd_en) begin
      prdata <= prdata;
    end
  end

  // --------------------------------------------------------------
  // Sampling mode decode
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_q <= 1'b0;
    end else if (ce) begin
      if (extended_control_mode) begin
        dual_q <= ctrl_reg[msr_pkg::CTRL_DUAL_EDGE_BIT];
      end else begin
        dual_q <= dual_edge_select;
      end
    end
  end
  assign dual_edge_mode = dual_q;
  assign quadrature_input_used = ~dual_q;

  // --------------------------------------------------------------
  // Output level and coupling selects
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvds_q <= 1'b0;
      dc_q <= 1'b0;
    end else if (ce) begin
      lvds_q <= bandgap_out_lvds_cm_select;
      dc_q <= common_mode_out_coupling_select;
    end
  end
  assign lvds_cm_high = lvds_q;
  assign inputs_dc_coupled = dc_q;

  // --------------------------------------------------------------
  // Power-on calibration wait
  // --------------------------------------------------------------
  // Wait length latched once after reset so a pin glitch cannot stretch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_long <= 1'b0;
      cal_cnt <= 32'h0000_0000;
      cal_state <= msr_pkg::MSR_CAL_WAIT;
      cal_start_q <= 1'b0;
    end else if (ce) begin
      cal_start_q <= 1'b0;
      case (cal_state)
        msr_pkg::MSR_CAL_WAIT: begin
          if (cal_cnt == 32'h0000_0000) begin
            wait_long <= power_on_cal_wait_select;
          end
          if (cal_cnt + 32'h0000_0001 >=
              (wait_long ? 32'(CAL_LONG) : 32'(CAL_SHORT)) &&
              cal_cnt != 32'h0000_0000) begin
            cal_state <= msr_pkg::MSR_CAL_GO;
          end
          cal_cnt <= cal_cnt + 32'h0000_0001;
        end
        msr_pkg::MSR_CAL_GO: begin
          cal_start_q <= 1'b1;
          cal_state <= msr_pkg::MSR_CAL_DONE;
        end
        msr_pkg::MSR_CAL_DONE: cal_state <= msr_pkg::MSR_CAL_DONE;
        default: cal_state <= msr_pkg::MSR_CAL_WAIT;
      endcase
    end
  end
  assign cal_start = cal_start_q;

  // --------------------------------------------------------------
  // Sync reference path
  // --------------------------------------------------------------
  // enable bit drives outputs
  assign sif.enable = sync_reg[msr_pkg::SYNC_REF_OUT_EN_BIT];
  assign sif.slave = sync_reg[msr_pkg::SYNC_SLAVE_BIT];
  assign sif.delay = sync_reg[msr_pkg::SYNC_DELAY_LSB +: msr_pkg::SYNC_DELAY_W];
  assign sif.ref_in = sync_reference_in;

  msr_ref_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sif(sif)
  );

  assign sync_reference_out_first = sif.ref_out;
  assign sync_reference_out_second = sif.ref_out;
  assign sync_aligned = sif.aligned;
endmodule
`default_nettype wire

// ===== verification/msr_ref_partner.sv
// Partner model: upstream converter reference output and board coupling pin
`timescale 1ns/10ps
`default_nettype none
module msr_ref_partner (
  input wire logic pclk,
  input wire logic run,
  input wire logic ac_mode,
  output logic ref_clk,
  output logic cm_pin
);
  logic [1:0] cnt = 2'h0;
  always @(posedge pclk) begin
    cnt <= run ? cnt + 2'h1 : 2'h0;
  end
  // Parks low when stopped, so no stale edge can realign us
  assign ref_clk = cnt[1];
  assign cm_pin = ac_mode ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== verification/msr_mode_select_assertions.sv
// Checker: port-level properties of the mode select block
`timescale 1ns/10ps
`default_nettype none
module msr_mode_select_assertions #(
  parameter int CAL_SHORT = 4,
  parameter int CAL_LONG = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic extended_control_enable_n,
  input wire logic dual_edge_select,
  input wire logic power_on_cal_wait_select,
  input wire logic bandgap_out_lvds_cm_select,
  input wire logic extended_control_mode,
  input wire logic dual_edge_mode,
  input wire logic quadrature_input_used,
  input wire logic lvds_cm_high,
  input wire logic cal_start,
  input wire logic sync_aligned,
  input wire logic sync_reference_out_first,
  input wire logic sync_reference_out_second
);
  // ----------------------------------------
  // Helper logic and properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int cnt;
  logic wsel;
  // Cycles since release; wait pin latched at the first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else cnt <= cnt + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wsel <= 1'b0;
    else if (cnt == 0) wsel <= power_on_cal_wait_select;
  end
  a_quad_inverse: assert property (quadrature_input_used == !dual_edge_mode)
    else $error("quadrature use not inverse of dual edge");
  // A frozen clock enable holds every register, so only enabled edges are judged
  a_ecm_track: assert property ($past(presetn) && $past(ce) |->
    extended_control_mode == !$past(extended_control_enable_n))
    else $error("extended mode not tracking its pin");
  a_dual_pin: assert property (
    !extended_control_mode && !$past(extended_control_mode) && $past(presetn) && $past(ce)
    |-> dual_edge_mode == $past(dual_edge_select))
    else $error("dual edge mode not following pin");
  a_ref_pair: assert property (sync_reference_out_first == sync_reference_out_second)
    else $error("reference outputs differ");
  // Alignment and mode exit may legally cut a period short; the first high
  // after enabling may be a runt, so only a rise after a full period is judged
  a_ref_quarter: assert property (@(posedge pclk)
    disable iff (!presetn || !ce || sync_aligned || !extended_control_mode)
    $rose(sync_reference_out_first) && $past(sync_reference_out_first, 3) |=>
    sync_reference_out_first ##1 !sync_reference_out_first ##1 !sync_reference_out_first
    ##1 sync_reference_out_first)
    else $error("reference output not quarter rate");
  a_cal_pulse: assert property (cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");
  a_cal_time: assert property (cal_start |->
    (wsel ? (cnt >= CAL_LONG - 1 && cnt <= CAL_LONG + 3)
    : (cnt >= CAL_SHORT - 1 && cnt <= CAL_SHORT + 3)))
    else $error("calibration start at wrong time");
  a_apb_map: assert property (psel && penable |->
    pready && pslverr == !(paddr inside {12'h000, 12'h004, 12'h038}))
    else $error("bus answer wrong for address");
  a_lvds_pin: assert property ($past(presetn) && $past(ce) |->
    lvds_cm_high == $past(bandgap_out_lvds_cm_select))
    else $error("output level select not following pin");
endmodule
`default_nettype wire

// ===== verification/msr_mode_select_tb.sv
// Testbench: self-checking run of the mode select block
`timescale 1ns/10ps
`default_nettype none
module msr_mode_select_tb;
  logic pclk = 1'b0;
  logic presetn, ce, psel, penable, pwrite, pready, pslverr, e, run, ac_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic extended_control_enable_n, dual_edge_select, power_on_cal_wait_select;
  logic bandgap_out_lvds_cm_select, common_mode_out_coupling_select, sync_reference_in;
  logic extended_control_mode, dual_edge_mode, quadrature_input_used, lvds_cm_high;
  logic inputs_dc_coupled, cal_start, sync_aligned;
  logic sync_reference_out_first, sync_reference_out_second;
  int n_errors = 0;
  int num_checks = 0;
  // ----------------------------------------
  // Clock, instances and shared tasks
  // ----------------------------------------
  always #5 pclk = ~pclk;
  msr_mode_select #(.CAL_SHORT(4), .CAL_LONG(8)) u_msr_mode_select (.*);
  msr_ref_partner u_msr_ref_partner (.pclk(pclk), .run(run), .ac_mode(ac_mode),
    .ref_clk(sync_reference_in), .cm_pin(common_mode_out_coupling_select));
  task automatic print_verdict();
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // Request held until pready is seen high; one idle edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // Highs over 16 cycles: 8 for a quarter-rate clock, 0 when off
  task automatic ref_run(input int x);
    int h;
    h = 0;
    repeat (16) begin
      @(posedge pclk);
      h += sync_reference_out_first;
    end
    chk(h, x);
  endtask
  task automatic do_reset(input logic w, input int lo);
    int n;
    power_on_cal_wait_select <= w;
    presetn <= 1'b0;
    tick(4);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cal_start !== 1'b1 && n < 40);
    chk(n >= lo && n <= lo + 3, 1'b1);
    chk(sync_reference_out_first, 1'b0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      dual_edge_select <= i[0];
      bandgap_out_lvds_cm_select <= i[1];
      ac_mode <= i[0] ^ i[1];
      tick(3);
      chk(dual_edge_mode, i[0]);
      chk(quadrature_input_used, !i[0]);
      chk(lvds_cm_high, i[1]);
      chk(inputs_dc_coupled, !(i[0] ^ i[1]));
    end
    // Clock enable low must freeze the decoded mode against a pin change
    ce <= 1'b0;
    dual_edge_select <= 1'b0;
    tick(3);
    chk(dual_edge_mode, 1'b1);
    ce <= 1'b1;
    dual_edge_select <= 1'b1;
    tick(3);
    chk(dual_edge_mode, 1'b1);
  endtask
  task automatic t_ecm();
    extended_control_enable_n <= 1'b0;
    tick(3);
    chk(extended_control_mode, 1'b1);
    chk(dual_edge_mode, 1'b0);
    rd(12'h004, 32'h0000000D);
    rd(12'h038, 32'h0);
    apb(1'b1, 12'h000, 32'h00000080);
    tick(2);
    chk(dual_edge_mode, 1'b1);
    rd(12'h000, 32'h00000080);
    apb(1'b0, 12'h008, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_slave();
    int n;
    ref_run(0);
    apb(1'b1, 12'h038, 32'h00000002);
    ref_run(8);
    run <= 1'b1;
    apb(1'b1, 12'h038, 32'h00000303);
    n = 0;
    while (sync_aligned !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(sync_aligned, 1'b1);
    rd(12'h038, 32'h00000303);
    ref_run(8);
  endtask
  task automatic t_exit();
    extended_control_enable_n <= 1'b1;
    // Slave bit clears one edge after mode exit, alignment flag one edge later
    tick(4);
    chk(extended_control_mode, 1'b0);
    chk(sync_aligned, 1'b0);
    apb(1'b1, 12'h038, 32'h00000302);
    rd(12'h038, 32'h0);
    ref_run(0);
    chk(dual_edge_mode, 1'b1);
  endtask
  initial begin
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    extended_control_enable_n = 1'b1;
    dual_edge_select = 1'b0;
    bandgap_out_lvds_cm_select = 1'b0;
    run = 1'b0;
    ac_mode = 1'b0;
    do_reset(1'b0, 4);
    do_reset(1'b1, 8);
    t_pins();
    t_ecm();
    t_slave();
    t_exit();
    print_verdict();
  end
  // Whole run is about 150 cycles; this only cuts a hang short
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule
bind msr_mode_select msr_mode_select_assertions #(.CAL_SHORT(CAL_SHORT),
  .CAL_LONG(CAL_LONG)) u_chk (.*);
`default_nettype wire
